// ==== async_sram_8k_by_8_tb.sv ====
// Self-checking bench for smc_ctrl against a behavioural memory.
// Assumes the memory model and the design sources are compiled first.
`timescale 1ns/1ns
module async_sram_8k_by_8_tb;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [12:0] req_address = 13'h0000;
    logic [7:0] req_wdata = 8'h00;
    logic retain_req = 1'b0;
    logic req_ready, rsp_valid, select_active_low_n, select_active_high;
    logic write_strobe_n, output_gate_n, shared_byte_lines_oe, mem_oe;
    logic [7:0] rsp_rdata, shared_byte_lines_out, mem_q, bus_in;
    logic [12:0] word_address_lines;
    int mismatches = 0;
    int num_checks = 0;
    always #5 clock = ~clock;
    assign bus_in = shared_byte_lines_oe ? shared_byte_lines_out : mem_q;
    smc_ctrl smc_ctrl_inst (.clock, .reset_n, .req_valid, .req_write, .req_address,
        .req_wdata, .retain_req, .req_ready, .rsp_valid, .rsp_rdata, .word_address_lines,
        .select_active_low_n, .select_active_high, .write_strobe_n, .output_gate_n,
        .shared_byte_lines_in(bus_in), .shared_byte_lines_out, .shared_byte_lines_oe);
    smc_sram_model smc_sram_model_inst (.word_address_lines, .select_active_low_n,
        .select_active_high, .write_strobe_n, .output_gate_n, .bus_in, .mem_q, .mem_oe);
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic tick();
        @(posedge clock);
        #1;
    endtask : tick
    task automatic issue(input logic wr, input logic [12:0] a, input logic [7:0] d);
        @(posedge clock);
        req_valid <= 1'b1;
        req_write <= wr;
        req_address <= a;
        req_wdata <= d;
        @(posedge clock);
        req_valid <= 1'b0;
        #1;
    endtask : issue
    task automatic do_write(input logic [12:0] a, input logic [7:0] d);
        int low;
        low = 0;
        issue(1'b1, a, d);
        for (int n = 0; n <= 30; n++) begin
            if (write_strobe_n === 1'b0) begin
                low++;
                chk("write address", {3'h0, a}, {3'h0, word_address_lines});
                chk("write data", {8'h00, d}, {8'h00, shared_byte_lines_out});
                chk("write drive", 16'h0001, {15'h0, shared_byte_lines_oe});
                chk("write selects", 16'h0001,
                    {14'h0, select_active_low_n, select_active_high});
            end
            if (req_ready === 1'b1) begin
                chk("strobe cycles", 16'h0008, low[15:0]);
                chk("write ready", 16'h0009, n[15:0]);
                return;
            end
            tick();
        end
        chk("write ready", 16'h0009, 16'hffff);
    endtask : do_write
    task automatic do_read(input logic [12:0] a, input logic [7:0] d);
        int seen;
        seen = 0;
        issue(1'b0, a, 8'h00);
        for (int n = 0; n <= 30; n++) begin
            if (n == 0) begin
                chk("read address", {3'h0, a}, {3'h0, word_address_lines});
                chk("read pins", 16'h0002, {13'h0, select_active_low_n, write_strobe_n,
                    output_gate_n});
            end
            if (rsp_valid === 1'b1) begin
                seen++;
                chk("read latency", 16'h000b, n[15:0]);
                chk("read data", {8'h00, d}, {8'h00, rsp_rdata});
            end
            if (req_ready === 1'b1) begin
                chk("read response", 16'h0001, seen[15:0]);
                chk("read ready", 16'h000f, n[15:0]);
                return;
            end
            tick();
        end
        chk("read ready", 16'h000f, 16'hffff);
    endtask : do_read
    task automatic t_retain();
        @(posedge clock);
        retain_req <= 1'b1;
        req_valid <= 1'b1;
        repeat (5) tick();
        chk("retain high select", 16'h0000, {15'h0, select_active_high});
        chk("retain low select", 16'h0001, {15'h0, select_active_low_n});
        @(posedge clock);
        retain_req <= 1'b0;
        req_valid <= 1'b0;
        #1;
        for (int n = 0; n < 10 && req_ready !== 1'b1; n++) tick();
        chk("retain ready", 16'h0001, {15'h0, req_ready});
        tick();
        chk("retain exit", 16'h0001, {15'h0, select_active_high});
    endtask : t_retain
    task automatic test_done();
        if (mismatches == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done
    // Controller and memory must never drive the bus together
    always @(posedge clock) begin
        if (shared_byte_lines_oe === 1'b1 && mem_oe === 1'b1) begin
            chk("contention", 16'h0, 16'h1);
        end
    end
    initial begin
        #100000;
        mismatches++;
        test_done();
    end
    initial begin
        repeat (4) @(posedge clock);
        reset_n <= 1'b1;
        tick();
        chk("idle pins", 16'h000e, {12'h0, select_active_low_n, select_active_high,
            write_strobe_n, shared_byte_lines_oe});
        do_write(13'h0000, 8'h5a);
        do_write(13'h1fff, 8'ha5);
        do_write(13'h0aaa, 8'h3c);
        do_read(13'h1fff, 8'ha5);
        do_read(13'h0000, 8'h5a);
        do_write(13'h0000, 8'hc3);
        t_retain();
        do_read(13'h0000, 8'hc3);
        do_read(13'h0aaa, 8'h3c);
        test_done();
    end
endmodule : async_sram_8k_by_8_tb

// ==== smc_ctrl.sv ====
// Controller that drives an 8K x 8 asynchronous static memory through its pins.
// Assumes memory pins are wired directly; bus level resolved outside from enables.
`timescale 1ns/1ns
`include "sram_defines.svh"

module smc_ctrl (
    // System
    input wire logic clock,
    input wire logic reset_n,
    // User request side
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [`SMC_ADDR_W-1:0] req_address,
    input wire logic [`SMC_DATA_W-1:0] req_wdata,
    input wire logic retain_req,
    output logic req_ready,
    output logic rsp_valid,
    output logic [`SMC_DATA_W-1:0] rsp_rdata,
    // Memory pins
    output logic [`SMC_ADDR_W-1:0] word_address_lines,
    output logic select_active_low_n,
    output logic select_active_high,
    output logic write_strobe_n,
    output logic output_gate_n,
    input wire logic [`SMC_DATA_W-1:0] shared_byte_lines_in,
    output logic [`SMC_DATA_W-1:0] shared_byte_lines_out,
    output logic shared_byte_lines_oe
);

    // ------------------------------------------------------------
    // State and registers
    // ------------------------------------------------------------
    smc_pkg::smc_state_t state_reg, state_next;
    logic [`SMC_CNT_W-1:0] cnt_reg, cnt_next;
    logic [`SMC_ADDR_W-1:0] addr_reg, addr_next;
    logic [`SMC_DATA_W-1:0] wdata_reg, wdata_next;
    logic [`SMC_DATA_W-1:0] rdata_reg, rdata_next;
    logic sel_n_reg, sel_n_next;
    logic sel_h_reg, sel_h_next;
    logic we_n_reg, we_n_next;
    logic oe_n_reg, oe_n_next;
    logic drv_reg, drv_next;
    logic rsp_reg, rsp_next;
    logic rdy_reg, rdy_next;

    wire cnt_done = (cnt_reg == `SMC_CNT_ONE);
    wire [`SMC_CNT_W-1:0] cnt_dec = cnt_reg - `SMC_CNT_ONE;
    wire take_req = (state_reg == smc_pkg::SMC_IDLE) && req_valid && !retain_req;
    wire go_sleep = (state_reg == smc_pkg::SMC_IDLE) && retain_req;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_dec;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        rdata_next = rdata_reg;
        sel_n_next = sel_n_reg;
        sel_h_next = sel_h_reg;
        we_n_next = we_n_reg;
        oe_n_next = oe_n_reg;
        drv_next = drv_reg;
        rsp_next = 1'b0;
        rdy_next = 1'b0;
        case (state_reg)
            smc_pkg::SMC_IDLE: begin
                cnt_next = `SMC_CNT_ZERO;
                sel_n_next = 1'b1;
                sel_h_next = 1'b1;
                if (take_req) begin
                    addr_next = req_address;
                    wdata_next = req_wdata;
                    sel_n_next = 1'b0;
                    if (req_write) begin
                        we_n_next = 1'b0;
                        oe_n_next = 1'b1;
                        drv_next = 1'b1;
                        cnt_next = `SMC_CNT_W'(`SMC_WP_CYC);
                        state_next = smc_pkg::SMC_WRITE;
                    end else begin
                        oe_n_next = 1'b0;
                        cnt_next = `SMC_CNT_W'(`SMC_RD_CYC);
                        state_next = smc_pkg::SMC_READ;
                    end
                end else if (go_sleep) begin
                    sel_h_next = 1'b0;
                    state_next = smc_pkg::SMC_SLEEP;
                end else begin
                    rdy_next = 1'b1;
                end
            end
            smc_pkg::SMC_READ: begin
                if (cnt_done) begin
                    rdata_next = shared_byte_lines_in;
                    rsp_next = 1'b1;
                    oe_n_next = 1'b1;
                    sel_n_next = 1'b1;
                    cnt_next = `SMC_CNT_W'(`SMC_HZ_CYC);
                    state_next = smc_pkg::SMC_RHZ;
                end
            end
            smc_pkg::SMC_RHZ: begin
                if (cnt_done) begin
                    rdy_next = 1'b1;
                    state_next = smc_pkg::SMC_IDLE;
                end
            end
            smc_pkg::SMC_WRITE: begin
                if (cnt_done) begin
                    we_n_next = 1'b1;
                    sel_n_next = 1'b1;
                    state_next = smc_pkg::SMC_WEND;
                end
            end
            smc_pkg::SMC_WEND: begin
                drv_next = 1'b0;
                rdy_next = 1'b1;
                state_next = smc_pkg::SMC_IDLE;
            end
            smc_pkg::SMC_SLEEP: begin
                if (!retain_req) begin
                    sel_h_next = 1'b1;
                    rdy_next = 1'b1;
                    state_next = smc_pkg::SMC_IDLE;
                end
            end
            default: begin
                state_next = smc_pkg::SMC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= smc_pkg::SMC_IDLE;
            cnt_reg <= `SMC_CNT_ZERO;
            addr_reg <= '0;
            wdata_reg <= '0;
            rdata_reg <= '0;
            sel_n_reg <= 1'b1;
            sel_h_reg <= 1'b1;
            we_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            drv_reg <= 1'b0;
            rsp_reg <= 1'b0;
            rdy_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            rdata_reg <= rdata_next;
            sel_n_reg <= sel_n_next;
            sel_h_reg <= sel_h_next;
            we_n_reg <= we_n_next;
            oe_n_reg <= oe_n_next;
            drv_reg <= drv_next;
            rsp_reg <= rsp_next;
            rdy_reg <= rdy_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Every output comes straight from a register
    assign word_address_lines = addr_reg;
    assign select_active_low_n = sel_n_reg;
    assign select_active_high = sel_h_reg;
    assign write_strobe_n = we_n_reg;
    assign output_gate_n = oe_n_reg;
    assign shared_byte_lines_out = wdata_reg;
    assign shared_byte_lines_oe = drv_reg;
    assign rsp_valid = rsp_reg;
    assign rsp_rdata = rdata_reg;
    assign req_ready = rdy_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Address held in write
    a_addr_stable_write: assert property (@(posedge clock) disable iff (!reset_n)
        (!we_n_reg && !sel_n_reg) |=> $stable(word_address_lines) || we_n_reg)
        else $error("address moved during write");
    a_no_contention: assert property (@(posedge clock) disable iff (!reset_n)
        !(shared_byte_lines_oe && !output_gate_n))
        else $error("controller drives while memory gate low");
    a_strobe_width: assert property (@(posedge clock) disable iff (!reset_n)
        $fell(write_strobe_n) |-> !write_strobe_n [*8])
        else $error("write strobe too short");
    a_data_stable: assert property (@(posedge clock) disable iff (!reset_n)
        !write_strobe_n |-> shared_byte_lines_oe
            && ($fell(write_strobe_n) || $stable(shared_byte_lines_out)))
        else $error("write data not stable");
    a_select_write: assert property (@(posedge clock) disable iff (!reset_n)
        !write_strobe_n |-> !select_active_low_n && select_active_high)
        else $error("write without selects");
    a_read_timing: assert property (@(posedge clock) disable iff (!reset_n)
        $fell(output_gate_n) |-> !output_gate_n [*8] ##1 !output_gate_n [*3] ##1 rsp_valid)
        else $error("read sampled too early or late");
    a_turnoff_gap: assert property (@(posedge clock) disable iff (!reset_n)
        $rose(output_gate_n) |-> !shared_byte_lines_oe [*4])
        else $error("drive during turn-off");
    a_retain_sel: assert property (@(posedge clock) disable iff (!reset_n)
        !select_active_high |-> select_active_low_n && write_strobe_n)
        else $error("access while retention");
    c_read: cover property (@(posedge clock) disable iff (!reset_n) rsp_valid);
    c_write: cover property (@(posedge clock) disable iff (!reset_n) $rose(write_strobe_n));
    c_sleep: cover property (@(posedge clock) disable iff (!reset_n) $fell(select_active_high));

endmodule : smc_ctrl

// ==== smc_pkg.sv ====
// Types for the static memory controller.
// Used by smc_ctrl only.
package smc_pkg;
    typedef enum logic [2:0] {
        SMC_IDLE  = 3'b000,
        SMC_READ  = 3'b001,
        SMC_RHZ   = 3'b010,
        SMC_WRITE = 3'b011,
        SMC_WEND  = 3'b100,
        SMC_SLEEP = 3'b101
    } smc_state_t;
endpackage : smc_pkg

// ==== smc_sram_model.sv ====
// Behavioural 8K x 8 static memory that faces smc_ctrl.
// Assumes the bench resolves the shared byte bus from shared_byte_lines_oe alone, taking mem_q otherwise.
`timescale 1ns/1ns
module smc_sram_model #(
    parameter int ACCESS_NS = 100,
    parameter int HOLD_NS = 10
) (
    // Memory pins
    input wire logic [12:0] word_address_lines,
    input wire logic select_active_low_n,
    input wire logic select_active_high,
    input wire logic write_strobe_n,
    input wire logic output_gate_n,
    input wire logic [7:0] bus_in,
    // Memory drive
    output logic [7:0] mem_q,
    output logic mem_oe
);
    logic [7:0] mem [0:8191];
    logic [7:0] last_q = 8'h00;
    // Deselect or retention gates every input
    wire selected = !select_active_low_n && select_active_high;
    // Write window is the overlap of all three
    wire writing = selected && !write_strobe_n;
    wire reading = selected && write_strobe_n && !output_gate_n;
    wire #(ACCESS_NS) reading_late = reading;
    // Data appears only after the access time
    assign mem_oe = reading && reading_late;
    // Released bus shows the inverse of the last byte, never a stale match
    // Old data stays on the pins after an address change
    wire [12:0] #(HOLD_NS) addr_held = word_address_lines;
    assign mem_q = mem_oe ? mem[addr_held] : ~last_q;
    always @(negedge writing) mem[word_address_lines] = bus_in;
    always @(posedge mem_oe) last_q = mem[word_address_lines];
endmodule : smc_sram_model

// ==== sram_defines.svh ====
// Timing constants for the asynchronous byte-wide static memory controller.
// Assumes a 100 MHz system clock (10 ns period).
`ifndef SRAM_DEFINES_SVH
`define SRAM_DEFINES_SVH

`define SMC_CLK_NS 10
// Least times and longest times both round up to whole clocks
`define SMC_T_CO_NS 100
`define SMC_T_OE_NS 50
`define SMC_T_OHZ_NS 35
`define SMC_T_WHZ_NS 35
`define SMC_T_DW_NS 40
`define SMC_T_AW_NS 80
`define SMC_T_CW_NS 80
`define SMC_T_WP_NS 60
`define SMC_T_OH_NS 10
`define SMC_RD_CYC ((`SMC_T_CO_NS + `SMC_CLK_NS - 1) / `SMC_CLK_NS + 1)
`define SMC_WP_CYC ((`SMC_T_WHZ_NS + `SMC_T_DW_NS + `SMC_CLK_NS - 1) / `SMC_CLK_NS)
`define SMC_HZ_CYC ((`SMC_T_OHZ_NS + `SMC_CLK_NS - 1) / `SMC_CLK_NS)
`define SMC_CNT_W 4
`define SMC_ADDR_W 13
`define SMC_DATA_W 8
`define SMC_CNT_ONE 4'h1
`define SMC_CNT_ZERO 4'h0

`endif
